// [hdl/reset_watchdog_sleep_control.sv]
// Added by the designer: the APB interface to the registers.
module reset_watchdog_sleep_control #(
	parameter int POR_HOLD = wdt_sleep_pkg::POR_HOLD_CYCLES,
	parameter int LP_TICK = wdt_sleep_pkg::LP_TICK_CYCLES
) (
	// Clock and power-on reset.
	input wire logic REF_CLK,
	input wire logic RESET,
	// APB register port.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Processor side.
	input wire logic GLOBAL_INT_ENABLE,
	input wire logic INT_PENDING,
	output logic CPU_HOLD,
	output logic SYS_RESTART,
	output logic [15:0] FETCH_ADDRESS,
	output logic [3:0] CPU_CLK_DIVIDE,
	output logic CLK_FORCE_INTERNAL,
	output logic INT_OSC_ENABLE,
	// Timer events.
	output logic SLEEP_TIMER_IRQ,
	output logic WATCHDOG_RESET,
	// Low-power oscillator trim.
	output logic LP_OSC_LOW_POWER,
	output logic [1:0] LP_OSC_BIAS,
	output logic [3:0] LP_OSC_FREQ_TRIM
);

	// True when the byte address selects the given register word.
	// Misaligned byte addresses never match, so they fall through to the error answer.
	function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
		hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	// Period in low-power ticks for a sleep period code.
	// The codes and their periods are local choices of this block.
	function automatic logic [13:0] sleep_ticks(input logic [1:0] sel);
		case (sel)
			2'h0: sleep_ticks = wdt_sleep_pkg::SLEEP_TICKS_0;
			2'h1: sleep_ticks = wdt_sleep_pkg::SLEEP_TICKS_1;
			2'h2: sleep_ticks = wdt_sleep_pkg::SLEEP_TICKS_2;
			default: sleep_ticks = wdt_sleep_pkg::SLEEP_TICKS_3;
		endcase
	endfunction

	logic setup_phase; // First cycle of an APB transfer.
	logic wr_en; // Write takes effect this cycle.
	logic mapped; // Address hits a register.
	logic [7:0] wbyte; // Low byte of write data.
	logic [7:0] trim_q; // Trim register.
	logic [1:0] sleep_sel_q; // Sleep period select.
	logic por_flag_q; // Power-on flag.
	logic wdr_flag_q; // Watchdog reset flag.
	logic wdt_en_q; // Watchdog enable, sticky until power-on.
	logic [1:0] wdt_cnt_q; // Overflows since last clear.
	logic [13:0] sleep_cnt_q; // Sleep timer in low-power ticks.
	logic [10:0] lp_div_q; // Divider for the low-power tick.
	logic lp_tick; // One-cycle low-power oscillator tick.
	logic overflow; // Sleep timer overflow this cycle.
	logic wdr_q; // Watchdog reset pulse.
	logic [19:0] hold_cnt_q; // Power-on hold counter.
	logic [1:0] wake_cnt_q; // Wake recovery tick counter.
	logic restart_q; // Restart pulse after any reset.
	logic [31:0] rdata_q; // Read data captured at setup.
	logic [7:0] scr_rd; // Status register read view.
	wdt_sleep_pkg::power_state_e state_q;

	assign setup_phase = PSEL && !PENABLE;
	assign wr_en = PSEL && PENABLE && PWRITE && !PSLVERR;
	assign wbyte = PWDATA[7:0];

	// Address decode of the mapped words.
	// Only the five words below answer; every other word gets an error response.
	// The decode looks at the whole address, so no aliases can appear.
	always_comb begin
		if (hit(PADDR, wdt_sleep_pkg::IDX_LP_OSC_TRIM)) begin
			mapped = 1'b1;
		end else if (hit(PADDR, wdt_sleep_pkg::IDX_WATCHDOG_CLEAR)) begin
			mapped = 1'b1;
		end else if (hit(PADDR, wdt_sleep_pkg::IDX_PROC_STATUS_CONTROL)) begin
			mapped = 1'b1;
		end else if (hit(PADDR, wdt_sleep_pkg::IDX_SLEEP_PERIOD)) begin
			mapped = 1'b1;
		end else if (hit(PADDR, wdt_sleep_pkg::IDX_TIMER_STATUS)) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// The slave never waits; an unmapped address answers with an error.
	// Zero wait states keep every transfer at exactly two clock cycles.
	// The error answer also blocks the write, through the write enable above.
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA = rdata_q;

	// Status register view; reserved bits read zero.
	// Bit 3 reads back as one for the whole time from sleep entry to the end of recovery.
	// Bit 7 is a live copy of the processor input and cannot be written.
	always_comb begin
		scr_rd = 8'h00;
		scr_rd[wdt_sleep_pkg::SCR_GIE_BIT] = GLOBAL_INT_ENABLE;
		scr_rd[wdt_sleep_pkg::SCR_WDR_FLAG_BIT] = wdr_flag_q;
		scr_rd[wdt_sleep_pkg::SCR_POR_FLAG_BIT] = por_flag_q;
		scr_rd[wdt_sleep_pkg::SCR_SLEEP_BIT] = (state_q == wdt_sleep_pkg::ST_SLEEP) ||
			(state_q == wdt_sleep_pkg::ST_WAKE);
		scr_rd[wdt_sleep_pkg::SCR_STOP_BIT] = (state_q == wdt_sleep_pkg::ST_HALT);
	end

	// Read data is captured in the setup cycle and shown in the access cycle.
	// Capturing one cycle early lets the read data come straight from a flip-flop.
	// The watchdog clear word is write-only and reads as zero.
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			rdata_q <= 32'h0000_0000;
		end else if (setup_phase && !PWRITE) begin
			if (hit(PADDR, wdt_sleep_pkg::IDX_LP_OSC_TRIM)) begin
				rdata_q <= {24'h00_0000, trim_q};
			end else if (hit(PADDR, wdt_sleep_pkg::IDX_PROC_STATUS_CONTROL)) begin
				rdata_q <= {24'h00_0000, scr_rd};
			end else if (hit(PADDR, wdt_sleep_pkg::IDX_SLEEP_PERIOD)) begin
				rdata_q <= {30'h0000_0000, sleep_sel_q};
			end else if (hit(PADDR, wdt_sleep_pkg::IDX_TIMER_STATUS)) begin
				rdata_q <= {15'h0000, wdt_en_q, wdt_cnt_q, sleep_cnt_q};
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end

	// Trim register; a write of the bad bias code keeps the old bias.
	// Bit 6 is reserved and always reads zero.
	// The boot code loads the calibration value after reset; until then the trim is zero.
	// Keeping the old bias protects the oscillator from a setting that may not start.
	always_ff @(posedge REF_CLK) begin
		if (RESET || wdr_q) begin
			trim_q <= wdt_sleep_pkg::TRIM_RESET;
		end else if (wr_en && hit(PADDR, wdt_sleep_pkg::IDX_LP_OSC_TRIM)) begin
			trim_q[wdt_sleep_pkg::TRIM_LOW_POWER_BIT] <= wbyte[7];
			trim_q[6] <= 1'b0;
			if (wbyte[5:4] != wdt_sleep_pkg::BIAS_RESERVED_BAD) begin
				trim_q[5:4] <= wbyte[5:4];
			end
			trim_q[3:0] <= wbyte[3:0];
		end
	end

	assign LP_OSC_LOW_POWER = trim_q[wdt_sleep_pkg::TRIM_LOW_POWER_BIT];
	assign LP_OSC_BIAS = trim_q[wdt_sleep_pkg::TRIM_BIAS_LSB +: 2];
	assign LP_OSC_FREQ_TRIM = trim_q[wdt_sleep_pkg::TRIM_FREQ_LSB +: 4];

	// Sleep period select register.
	// The code selects how many low-power ticks make one sleep interval.
	always_ff @(posedge REF_CLK) begin
		if (RESET || wdr_q) begin
			sleep_sel_q <= wdt_sleep_pkg::SLEEP_SEL_RESET;
		end else if (wr_en && hit(PADDR, wdt_sleep_pkg::IDX_SLEEP_PERIOD)) begin
			sleep_sel_q <= wbyte[1:0];
		end
	end

	// Reset cause flags; software may only clear them and a set wins over a clear.
	// The watchdog flag survives its own reset so that software can see the cause.
	// A power-on reset sets the power-on flag and clears the watchdog flag.
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			por_flag_q <= wdt_sleep_pkg::SCR_POR_VALUE[wdt_sleep_pkg::SCR_POR_FLAG_BIT];
			wdr_flag_q <= wdt_sleep_pkg::SCR_POR_VALUE[wdt_sleep_pkg::SCR_WDR_FLAG_BIT];
		end else if (wdr_q) begin
			por_flag_q <= 1'b0;
			wdr_flag_q <= 1'b1;
		end else if (wr_en && hit(PADDR, wdt_sleep_pkg::IDX_PROC_STATUS_CONTROL)) begin
			// Writing one leaves a flag alone, writing zero clears it.
			if (!wbyte[wdt_sleep_pkg::SCR_POR_FLAG_BIT]) begin
				por_flag_q <= 1'b0;
			end
			if (!wbyte[wdt_sleep_pkg::SCR_WDR_FLAG_BIT]) begin
				wdr_flag_q <= 1'b0;
			end
		end
	end

	// The watchdog arms once the power-on flag is gone; only power-on disarms it.
	// Nothing but RESET clears the enable, so a watchdog reset keeps it armed.
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			wdt_en_q <= 1'b0;
		end else if (!por_flag_q) begin
			wdt_en_q <= 1'b1;
		end
	end

	// Divider that makes the low-power oscillator tick.
	// The tick period is a parameter so that a bench can run the timers fast.
	// The fraction of a cycle lost per tick is small against the oscillator's spread.
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			lp_div_q <= 11'h000;
		end else if (lp_tick) begin
			lp_div_q <= 11'h000;
		end else begin
			lp_div_q <= lp_div_q + 11'h001;
		end
	end

	assign lp_tick = (lp_div_q == 11'(LP_TICK - 1));
	assign overflow = lp_tick && (sleep_cnt_q == sleep_ticks(sleep_sel_q) - 14'h0001);

	// Sleep timer; the special clear value restarts it.
	// The range check recovers a count left too high by a shorter period code.
	// A clear on the same edge as a tick wins, and that tick is lost.
	always_ff @(posedge REF_CLK) begin
		if (RESET || wdr_q) begin
			sleep_cnt_q <= 14'h0000;
		end else if (wr_en && hit(PADDR, wdt_sleep_pkg::IDX_WATCHDOG_CLEAR) &&
			wbyte == wdt_sleep_pkg::WDT_CLEAR_BOTH) begin
			sleep_cnt_q <= 14'h0000;
		end else if (overflow || sleep_cnt_q >= sleep_ticks(sleep_sel_q)) begin
			sleep_cnt_q <= 14'h0000;
		end else if (lp_tick) begin
			sleep_cnt_q <= sleep_cnt_q + 14'h0001;
		end
	end

	// Sleep timer interrupt pulse.
	// The pulse follows the overflow by one cycle and lasts exactly one cycle.
	always_ff @(posedge REF_CLK) begin
		if (RESET || wdr_q) begin
			SLEEP_TIMER_IRQ <= 1'b0;
		end else begin
			SLEEP_TIMER_IRQ <= overflow;
		end
	end

	// Watchdog count of overflows; any write to the clear register empties it.
	// A clear on the same edge as an overflow wins, so software can always catch up.
	always_ff @(posedge REF_CLK) begin
		if (RESET || wdr_q) begin
			wdt_cnt_q <= 2'h0;
		end else if (wr_en && hit(PADDR, wdt_sleep_pkg::IDX_WATCHDOG_CLEAR)) begin
			wdt_cnt_q <= 2'h0;
		end else if (overflow && wdt_en_q) begin
			wdt_cnt_q <= wdt_cnt_q + 2'h1;
		end
	end

	// Watchdog reset pulse when the count reaches its limit.
	// The pulse resets the block itself on the following edge.
	always_ff @(posedge REF_CLK) begin
		if (RESET || wdr_q) begin
			wdr_q <= 1'b0;
		end else begin
			wdr_q <= wdt_en_q && (wdt_cnt_q == wdt_sleep_pkg::WDT_LIMIT);
		end
	end

	assign WATCHDOG_RESET = wdr_q;

	// Restart pulse after either reset: fetch from zero and interrupts off.
	// The pulse also stands for the whole time RESET is held.
	always_ff @(posedge REF_CLK) begin
		if (RESET || wdr_q) begin
			restart_q <= 1'b1;
		end else begin
			restart_q <= 1'b0;
		end
	end

	assign SYS_RESTART = restart_q;
	assign FETCH_ADDRESS = wdt_sleep_pkg::FETCH_RESTART_ADDR;

	// Processor clock divider setting, internal oscillator by eight after reset.
	// No register of this block changes the setting, so it holds its reset value.
	always_ff @(posedge REF_CLK) begin
		if (RESET || wdr_q) begin
			CPU_CLK_DIVIDE <= wdt_sleep_pkg::CPU_CLK_DIV_RESET;
		end
	end

	// Power state machine: power-on hold, run, sleep, wake recovery and halt.
	// A watchdog reset skips the supply hold, since the supply is already stable.
	// Recovery counts whole ticks, so it lasts between two and three tick periods.
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			state_q <= wdt_sleep_pkg::ST_POR_WAIT;
			hold_cnt_q <= 20'h00000;
			wake_cnt_q <= 2'h0;
		end else if (wdr_q) begin
			state_q <= wdt_sleep_pkg::ST_RUN;
			wake_cnt_q <= 2'h0;
		end else begin
			case (state_q)
				wdt_sleep_pkg::ST_POR_WAIT: begin
					// Hold the processor off while the supply settles.
					if (hold_cnt_q == 20'(POR_HOLD - 1)) begin
						state_q <= wdt_sleep_pkg::ST_RUN;
					end else begin
						hold_cnt_q <= hold_cnt_q + 20'h00001;
					end
				end
				wdt_sleep_pkg::ST_RUN: begin
					// Stop has priority over sleep in the same write.
					if (wr_en && hit(PADDR, wdt_sleep_pkg::IDX_PROC_STATUS_CONTROL)) begin
						if (wbyte[wdt_sleep_pkg::SCR_STOP_BIT]) begin
							state_q <= wdt_sleep_pkg::ST_HALT;
						end else if (wbyte[wdt_sleep_pkg::SCR_SLEEP_BIT]) begin
							state_q <= wdt_sleep_pkg::ST_SLEEP;
						end
					end
				end
				wdt_sleep_pkg::ST_SLEEP: begin
					// Any pending interrupt wakes, global enable or not.
					if (INT_PENDING) begin
						state_q <= wdt_sleep_pkg::ST_WAKE;
						wake_cnt_q <= 2'h0;
					end
				end
				wdt_sleep_pkg::ST_WAKE: begin
					// Oscillator recovery over three low-power ticks.
					if (lp_tick) begin
						if (wake_cnt_q == 2'(wdt_sleep_pkg::WAKE_LP_TICKS - 1)) begin
							state_q <= wdt_sleep_pkg::ST_RUN;
						end else begin
							wake_cnt_q <= wake_cnt_q + 2'h1;
						end
					end
				end
				wdt_sleep_pkg::ST_HALT: begin
					// Only a reset leaves the halted state.
					state_q <= wdt_sleep_pkg::ST_HALT;
				end
				default: begin
					state_q <= wdt_sleep_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Processor runs only in the run state.
	// Everything outside the run state holds the processor off.
	assign CPU_HOLD = (state_q != wdt_sleep_pkg::ST_RUN);
	// Clock select is forced internal from sleep entry until recovery ends,
	// after which software must pick an external source itself.
	assign CLK_FORCE_INTERNAL = (state_q == wdt_sleep_pkg::ST_SLEEP) ||
		(state_q == wdt_sleep_pkg::ST_WAKE);
	// Internal oscillator stops in sleep and restarts at once on wake.
	assign INT_OSC_ENABLE = (state_q != wdt_sleep_pkg::ST_SLEEP);

endmodule

// [hdl/wdt_sleep_pkg.sv]
package wdt_sleep_pkg;

	// Register word indices; the byte address on the bus is four times the index.
	localparam logic [9:0] IDX_LP_OSC_TRIM = 10'h036;
	localparam logic [9:0] IDX_WATCHDOG_CLEAR = 10'h0e3;
	localparam logic [9:0] IDX_PROC_STATUS_CONTROL = 10'h0ff;
	localparam logic [9:0] IDX_SLEEP_PERIOD = 10'h100;
	localparam logic [9:0] IDX_TIMER_STATUS = 10'h101;

	// Field positions of the low-power oscillator trim register.
	localparam int TRIM_LOW_POWER_BIT = 7;
	localparam int TRIM_BIAS_LSB = 4;
	localparam int TRIM_FREQ_LSB = 0;
	localparam logic [1:0] BIAS_RESERVED_BAD = 2'h2;
	localparam logic [7:0] TRIM_RESET = 8'h00;

	// Field positions of the status and control register.
	localparam int SCR_GIE_BIT = 7;
	localparam int SCR_WDR_FLAG_BIT = 5;
	localparam int SCR_POR_FLAG_BIT = 4;
	localparam int SCR_SLEEP_BIT = 3;
	localparam int SCR_STOP_BIT = 0;
	localparam logic [7:0] SCR_POR_VALUE = 8'h10;

	// Any write clears the watchdog; this value also clears the sleep timer.
	localparam logic [7:0] WDT_CLEAR_BOTH = 8'h38;
	localparam logic [1:0] WDT_LIMIT = 2'h3;

	// Timing figures in their own units and the cycle counts derived from them.
	localparam longint CLK_HZ = 50000000;
	localparam longint LP_OSC_HZ = 32768;
	localparam int LP_TICK_CYCLES = int'(CLK_HZ / LP_OSC_HZ);
	localparam int WAKE_LP_TICKS = 3;
	localparam longint POR_HOLD_MS = 20;
	localparam int POR_HOLD_CYCLES = int'((CLK_HZ * POR_HOLD_MS) / 1000);

	// Clocking after reset: fetch address and internal oscillator divider.
	localparam logic [15:0] FETCH_RESTART_ADDR = 16'h0000;
	localparam logic [3:0] CPU_CLK_DIV_RESET = 4'h8;

	// Sleep period select and the period of each code in low-power ticks.
	localparam logic [1:0] SLEEP_SEL_RESET = 2'h0;
	localparam logic [13:0] SLEEP_TICKS_0 = 14'h0040;
	localparam logic [13:0] SLEEP_TICKS_1 = 14'h0100;
	localparam logic [13:0] SLEEP_TICKS_2 = 14'h0400;
	localparam logic [13:0] SLEEP_TICKS_3 = 14'h2000;

	// Processor power states.
	typedef enum logic [2:0] {
		ST_POR_WAIT = 3'b000,
		ST_RUN = 3'b001,
		ST_SLEEP = 3'b010,
		ST_WAKE = 3'b011,
		ST_HALT = 3'b100
	} power_state_e;

endpackage

// [tb/reset_watchdog_sleep_control_bench.sv]
module reset_watchdog_sleep_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// Design ports.
	logic REF_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, q;
	logic GLOBAL_INT_ENABLE, INT_PENDING, CPU_HOLD, SYS_RESTART, CLK_FORCE_INTERNAL;
	logic INT_OSC_ENABLE, SLEEP_TIMER_IRQ, WATCHDOG_RESET, LP_OSC_LOW_POWER, serr;
	logic [15:0] FETCH_ADDRESS;
	logic [3:0] CPU_CLK_DIVIDE, LP_OSC_FREQ_TRIM;
	logic [1:0] LP_OSC_BIAS;
	logic [7:0] v, trim;
	// Counters of the run.
	int n_errors, n_tests, cyc, n, k;
	// Short hold time, short low-power tick and register word indices.
	localparam int POR = 20;
	localparam int LPT = 16;
	localparam int WD_CYC = int'(wdt_sleep_pkg::WDT_LIMIT) * int'(wdt_sleep_pkg::SLEEP_TICKS_0) * LPT;
	localparam logic [9:0] TRIM = wdt_sleep_pkg::IDX_LP_OSC_TRIM;
	localparam logic [9:0] SCR = wdt_sleep_pkg::IDX_PROC_STATUS_CONTROL;
	localparam logic [9:0] WDC = wdt_sleep_pkg::IDX_WATCHDOG_CLEAR;
	reset_watchdog_sleep_control #(.POR_HOLD(POR), .LP_TICK(LPT)) reset_watchdog_sleep_control_i (
		.REF_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
		.PSLVERR, .GLOBAL_INT_ENABLE, .INT_PENDING, .CPU_HOLD, .SYS_RESTART,
		.FETCH_ADDRESS, .CPU_CLK_DIVIDE, .CLK_FORCE_INTERNAL, .INT_OSC_ENABLE,
		.SLEEP_TIMER_IRQ, .WATCHDOG_RESET, .LP_OSC_LOW_POWER, .LP_OSC_BIAS, .LP_OSC_FREQ_TRIM
	);
	// The 50 MHz clock.
	initial begin
		REF_CLK = 1'b0;
		forever #10 REF_CLK = ~REF_CLK;
	end
	// Prints the counts and the verdict, then stops.
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the enable input is redrawn at each setup.
	task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge REF_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= {idx, 2'b00};
		PWDATA <= {24'h0, d};
		GLOBAL_INT_ENABLE <= 1'($urandom);
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		q = PRDATA;
		serr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// Trim value expected after a write; bias code 10b keeps the old bias.
	function automatic logic [7:0] trim_next(input logic [7:0] old, input logic [7:0] w);
		trim_next = {w[7], 1'b0, (w[5:4] == 2'h2) ? old[5:4] : w[5:4], w[3:0]};
	endfunction
	// Power-on reset, restart state, hold time and status value.
	task automatic reset_cycle();
		@(posedge REF_CLK);
		RESET <= 1'b1;
		repeat (4) @(posedge REF_CLK);
		RESET <= 1'b0;
		#1 chk({10'h0, SYS_RESTART, CPU_HOLD, CPU_CLK_DIVIDE, FETCH_ADDRESS}, 32'h38_0000);
		n = 0;
		while (CPU_HOLD !== 1'b0 && n < 200) begin
			@(posedge REF_CLK);
			n++;
		end
		chk(32'(n >= POR - 2 && n <= POR + 3), 32'h1);
		xfer(1'b0, SCR, 8'h0);
		chk(q, {24'h0, GLOBAL_INT_ENABLE, 7'h10});
	endtask
	// Cuts a hang short.
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			print_verdict();
		end
	end
	// Main sequence.
	initial begin
		{RESET, PSEL, PENABLE, PWRITE, GLOBAL_INT_ENABLE, INT_PENDING} = 6'h20;
		PADDR = 12'h0;
		PWDATA = 32'h0;
		void'($urandom(45317));
		reset_cycle();
		xfer(1'b0, 10'h001, 8'h0);
		chk({serr, q[30:0]}, 32'h8000_0000);
		xfer(1'b0, TRIM, 8'h0);
		chk(q, 32'h0);
		trim = 8'h0;
		for (int i = 0; i < 24; i++) begin
			v = (i < 2) ? 8'h85 ^ 8'(i * 8'hb0) : 8'($urandom);
			if (v[5:4] == wdt_sleep_pkg::BIAS_RESERVED_BAD) begin
				v[5:4] = 2'h3;
			end
			xfer(1'b1, TRIM, v);
			trim = trim_next(trim, v);
			#1 chk({24'h0, LP_OSC_LOW_POWER, 1'b0, LP_OSC_BIAS, LP_OSC_FREQ_TRIM}, {24'h0, trim});
		end
		xfer(1'b1, SCR, 8'h30);
		xfer(1'b0, SCR, 8'h0);
		chk(q, {24'h0, GLOBAL_INT_ENABLE, 7'h10});
		xfer(1'b1, SCR, 8'h00);
		xfer(1'b0, SCR, 8'h0);
		chk(q, {24'h0, GLOBAL_INT_ENABLE, 7'h00});
		xfer(1'b1, WDC, 8'h38);
		xfer(1'b0, wdt_sleep_pkg::IDX_TIMER_STATUS, 8'h0);
		chk(32'(q[16:14] == 3'b100 && q[13:0] <= 14'h1), 32'h1);
		xfer(1'b0, WDC, 8'h0);
		chk(q, 32'h0);
		xfer(1'b1, SCR, 8'h08);
		repeat (40) @(posedge REF_CLK);
		#1 chk({29'h0, INT_OSC_ENABLE, CLK_FORCE_INTERNAL, CPU_HOLD}, 32'h3);
		@(posedge REF_CLK);
		INT_PENDING <= 1'b1;
		n = 0;
		while (CPU_HOLD !== 1'b0 && n < 6000) begin
			@(posedge REF_CLK);
			n++;
		end
		INT_PENDING <= 1'b0;
		chk(32'(n >= 2 * LPT && n <= 3 * LPT + 3), 32'h1);
		#1 chk({30'h0, CLK_FORCE_INTERNAL, INT_OSC_ENABLE}, 32'h1);
		xfer(1'b1, SCR, 8'h01);
		repeat (30) @(posedge REF_CLK);
		#1 chk({31'h0, CPU_HOLD}, 32'h1);
		reset_cycle();
		// Watchdog: arm it, clear both counters, then let three overflows pass.
		xfer(1'b1, SCR, 8'h00);
		xfer(1'b1, TRIM, 8'h85);
		xfer(1'b1, WDC, wdt_sleep_pkg::WDT_CLEAR_BOTH);
		n = 0;
		k = 0;
		while (WATCHDOG_RESET !== 1'b1 && n < 2 * WD_CYC) begin
			@(posedge REF_CLK);
			n++;
			if (SLEEP_TIMER_IRQ === 1'b1) begin
				k++;
			end
		end
		chk(32'(k), 32'h3);
		chk(32'(n >= WD_CYC - LPT && n <= WD_CYC + 4), 32'h1);
		#1 chk({24'h0, LP_OSC_LOW_POWER, LP_OSC_BIAS, LP_OSC_FREQ_TRIM, CPU_HOLD}, 32'h0);
		xfer(1'b0, SCR, 8'h0);
		chk(q, {24'h0, GLOBAL_INT_ENABLE, 7'h20});
		xfer(1'b1, SCR, 8'h10);
		xfer(1'b0, SCR, 8'h0);
		chk(q, {24'h0, GLOBAL_INT_ENABLE, 7'h00});
		xfer(1'b0, wdt_sleep_pkg::IDX_TIMER_STATUS, 8'h0);
		chk(32'(q[16:14] == 3'b100), 32'h1);
		print_verdict();
	end
endmodule

// [tb/rwsc_props.sv]
module rwsc_props #(
	parameter int LP_TICK = wdt_sleep_pkg::LP_TICK_CYCLES
) (
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RESET,
	// Register port.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	// Processor, timer and trim side.
	input wire logic GLOBAL_INT_ENABLE,
	input wire logic INT_PENDING,
	input wire logic CPU_HOLD,
	input wire logic SYS_RESTART,
	input wire logic [3:0] CPU_CLK_DIVIDE,
	input wire logic CLK_FORCE_INTERNAL,
	input wire logic INT_OSC_ENABLE,
	input wire logic SLEEP_TIMER_IRQ,
	input wire logic WATCHDOG_RESET,
	input wire logic LP_OSC_LOW_POWER,
	input wire logic [1:0] LP_OSC_BIAS,
	input wire logic [3:0] LP_OSC_FREQ_TRIM
);
	// Byte addresses of the watched registers.
	localparam logic [11:0] A_TRIM = {wdt_sleep_pkg::IDX_LP_OSC_TRIM, 2'b00};
	localparam logic [11:0] A_SCR = {wdt_sleep_pkg::IDX_PROC_STATUS_CONTROL, 2'b00};
	// Wake recovery spans two to three low-power ticks.
	localparam int WAKE_MIN = 2 * LP_TICK;
	localparam int WAKE_MAX = 3 * LP_TICK + 2;
	// Clocks spent in wake recovery so far.
	int wake_q;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	// Counts while the oscillator runs again but the clock is still forced.
	always_ff @(posedge REF_CLK) begin
		if (CLK_FORCE_INTERNAL && INT_OSC_ENABLE) begin
			wake_q <= wake_q + 1;
		end else begin
			wake_q <= 0;
		end
	end
	// Completed writes and a read setup cycle.
	sequence trim_wr_s;
		PSEL && PENABLE && PWRITE && PADDR == A_TRIM;
	endsequence
	sequence scr_wr_s;
		PSEL && PENABLE && PWRITE && PADDR == A_SCR && !CPU_HOLD;
	endsequence
	sequence scr_rd_s;
		PSEL && !PENABLE && !PWRITE && PADDR == A_SCR;
	endsequence
	trim_fields_a: assert property (
		trim_wr_s |=> LP_OSC_LOW_POWER == $past(PWDATA[7]) && LP_OSC_FREQ_TRIM == $past(PWDATA[3:0]))
		else $error("trim mode or frequency not taken");
	bias_guard_a: assert property (
		trim_wr_s |=> LP_OSC_BIAS == (($past(PWDATA[5:4]) == 2'h2) ? $past(LP_OSC_BIAS)
		: $past(PWDATA[5:4]))) else $error("bias field wrong after write");
	restart_state_a: assert property (
		$fell(RESET) |-> SYS_RESTART && CPU_HOLD && CPU_CLK_DIVIDE == 4'h8)
		else $error("restart state wrong after reset");
	sleep_entry_a: assert property (
		scr_wr_s ##0 (PWDATA[3] && !PWDATA[0]) |=> !INT_OSC_ENABLE && CLK_FORCE_INTERNAL && CPU_HOLD)
		else $error("sleep not entered");
	sleep_holds_a: assert property (
		!INT_OSC_ENABLE && !INT_PENDING && !WATCHDOG_RESET |=> !INT_OSC_ENABLE)
		else $error("left sleep without interrupt");
	wake_start_a: assert property (
		!INT_OSC_ENABLE && INT_PENDING |=> INT_OSC_ENABLE && CLK_FORCE_INTERNAL && CPU_HOLD)
		else $error("wake not started");
	recovery_time_a: assert property (
		$fell(CLK_FORCE_INTERNAL) && !SYS_RESTART |-> wake_q >= WAKE_MIN && wake_q <= WAKE_MAX)
		else $error("oscillator recovery time wrong");
	halt_holds_a: assert property (
		scr_wr_s ##0 PWDATA[0] |=> CPU_HOLD [*8]) else $error("halt not held");
	gie_mirror_a: assert property (
		scr_rd_s |=> PRDATA[7] == $past(GLOBAL_INT_ENABLE)) else $error("enable mirror wrong");
	wdr_restart_a: assert property (
		WATCHDOG_RESET |=> SYS_RESTART && !WATCHDOG_RESET && !CPU_HOLD &&
		CPU_CLK_DIVIDE == 4'h8 && !LP_OSC_LOW_POWER && LP_OSC_BIAS == 2'h0)
		else $error("watchdog restart wrong");
	irq_pulse_a: assert property (
		SLEEP_TIMER_IRQ |=> !SLEEP_TIMER_IRQ) else $error("timer event longer than a cycle");
endmodule

bind reset_watchdog_sleep_control rwsc_props #(.LP_TICK(LP_TICK)) rwsc_props_i (
	.REF_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
	.GLOBAL_INT_ENABLE, .INT_PENDING, .CPU_HOLD, .SYS_RESTART, .CPU_CLK_DIVIDE,
	.CLK_FORCE_INTERNAL, .INT_OSC_ENABLE, .SLEEP_TIMER_IRQ, .WATCHDOG_RESET,
	.LP_OSC_LOW_POWER, .LP_OSC_BIAS, .LP_OSC_FREQ_TRIM
);
